// ---- hw/fault_log_pkg.sv ----
// Constants shared by the fault-log preamble formatter.
// Assumes byte 0 of the preamble is the first byte the host reads.
package fault_log_pkg;

  // ==========================================================
  // Preamble layout, byte offsets
  localparam int PRE_BYTES = 72;      // Bytes 0..71
  localparam int LAST_PRE_BYTE = 71;  // End of preamble
  localparam int OFS_POS = 0;         // Captured write-pointer position
  localparam int OFS_COUNT = 1;       // Valid cyclic byte count
  localparam int OFS_TS = 2;          // Timestamp, bytes 2..7
  localparam int TS_BYTES = 6;        // Timestamp byte count
  localparam int OFS_READ = 8;        // Peak/minimum block, bytes 8..47
  localparam int OFS_STAT = 48;       // Status block, bytes 48..71

  // ==========================================================
  // Field sizes
  localparam int CHANNELS = 8;        // Output channels
  localparam int READ_SLOTS = 10;     // Eight channels plus vin and temp
  localparam int BYTES_PER_SLOT = 4;  // Peak lo/hi, min lo/hi
  localparam int BYTES_PER_STAT = 3;  // Vout, mfr, mfr2 low byte
  localparam int TS_BITS = 41;        // Shared-clock counter width
  localparam int TS_STEP_US = 200;    // One counter step in microseconds
  localparam int LOOP_BYTES = 46;     // Cyclic loop length

  // ==========================================================
  // Reading slot sources, in preamble order
  localparam logic [1:0] SRC_CHAN = 2'h0;
  localparam logic [1:0] SRC_VIN = 2'h1;
  localparam logic [1:0] SRC_TEMP = 2'h2;
  localparam int SLOT_VIN = 2;        // Vin sits after channels 0 and 1
  localparam int SLOT_TEMP = 5;       // Temp sits after channels 2 and 3

  // ==========================================================
  // Link-side read states
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_PRE = 2'b01,
    LINK_CYC = 2'b10
  } link_state_t;

endpackage

// ---- hw/bit_sync2.sv ----
// Two flip-flop level synchroniser.
// Assumes the input is a level that stays put for several target clocks.
`timescale 1ns/1ns
`default_nettype none
module bit_sync2
(
  // Destination clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Level in and synchronised level out
  input wire logic din,
  output logic dout
);

  logic meta; // First stage, read only by the second stage

  // ==========================================================
  // Synchroniser stages
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // bit_sync2
`default_nettype wire

// ---- hw/fault_log_preamble_formatter.sv ----
// Fault-log preamble formatter: captures the fault snapshot on clk_sys
// and serves the 72 preamble bytes, then the cyclic positions, on the
// link clock. Assumes all snapshot inputs are clk_sys logic, and the
// link-side frame and read strobe come from logic on link_clk.
`timescale 1ns/1ns
`default_nettype none
module fault_log_preamble_formatter
(
  // System clock domain
  input wire logic clk_sys,
  input wire logic nrst,
  // Fault capture request and snapshot sources (clk_sys)
  input wire logic capture,
  input wire logic [7:0] write_pos,
  input wire logic [7:0] valid_count,
  input wire logic [40:0] shared_clock_timestamp,
  input wire logic [7:0][15:0] vout_peak,
  input wire logic [7:0][15:0] vout_min,
  input wire logic [15:0] vin_peak,
  input wire logic [15:0] vin_min,
  input wire logic [15:0] temp_peak,
  input wire logic [15:0] temp_min,
  input wire logic [7:0][7:0] status_vout,
  input wire logic [7:0][7:0] status_mfr,
  input wire logic [7:0][15:0] status_mfr2,
  // Capture status (clk_sys)
  output logic capture_busy,
  // Link clock domain
  input wire logic link_clk,
  // Link read side (link_clk)
  input wire logic frame,
  input wire logic rd_strobe,
  input wire logic [7:0] cyc_byte,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  output logic cyc_mode,
  output logic [5:0] cyc_pos,
  output logic log_ready
);

  localparam int SNAP_W = fault_log_pkg::PRE_BYTES * 8;

  // ==========================================================
  // Slot decode: which source feeds reading slot s
  function automatic logic [1:0] slot_src(input int s);
    if (s == fault_log_pkg::SLOT_VIN)
      return fault_log_pkg::SRC_VIN;
    else if (s == fault_log_pkg::SLOT_TEMP)
      return fault_log_pkg::SRC_TEMP;
    else
      return fault_log_pkg::SRC_CHAN;
  endfunction

  // Channel number behind a channel slot
  function automatic int slot_chan(input int s);
    if (s < fault_log_pkg::SLOT_VIN)
      return s;
    else if (s < fault_log_pkg::SLOT_TEMP)
      return s - 1;
    else
      return s - 2;
  endfunction

  // ==========================================================
  // Preamble image assembled from the live sources
  logic [SNAP_W-1:0] image; // Byte k at bits [8k+7:8k]

  always_comb
  begin
    image = '0;
    image[fault_log_pkg::OFS_POS*8 +: 8] = write_pos;
    image[fault_log_pkg::OFS_COUNT*8 +: 8] = valid_count;
    // Bit 40 lands alone in byte 7, upper bits stay zero
    image[fault_log_pkg::OFS_TS*8 +: fault_log_pkg::TS_BITS] =
      shared_clock_timestamp;
    for (int s = 0; s < fault_log_pkg::READ_SLOTS; s++)
    begin
      // Peak word then minimum word, low byte first
      case (slot_src(s))
        fault_log_pkg::SRC_VIN:
        begin
          image[(fault_log_pkg::OFS_READ + 4*s)*8 +: 32] =
            {vin_min, vin_peak};
        end
        fault_log_pkg::SRC_TEMP:
        begin
          image[(fault_log_pkg::OFS_READ + 4*s)*8 +: 32] =
            {temp_min, temp_peak};
        end
        default:
        begin
          image[(fault_log_pkg::OFS_READ + 4*s)*8 +: 32] =
            {vout_min[slot_chan(s)], vout_peak[slot_chan(s)]};
        end
      endcase
    end
    for (int c = 0; c < fault_log_pkg::CHANNELS; c++)
    begin
      // Upper reserved half of the second status word is dropped
      image[(fault_log_pkg::OFS_STAT + 3*c)*8 +: 24] =
        {status_mfr2[c][7:0], status_mfr[c], status_vout[c]};
    end
  end

  // ==========================================================
  // System side: snapshot hold and request toggle
  logic [SNAP_W-1:0] snap_sys; // Held until the link side copies it
  logic [SNAP_W-1:0] next_snap_sys;
  logic req; // Toggles once per accepted capture
  logic next_req;
  logic ack_sync; // Link acknowledge, synchronised to clk_sys
  logic next_busy;

  // A new capture is refused while the link has not copied the last one,
  // so the held snapshot never changes while it is being crossed
  always_comb
  begin
    next_snap_sys = snap_sys;
    next_req = req;
    if (capture && (req == ack_sync))
    begin
      next_snap_sys = image;
      next_req = ~req;
    end
    next_busy = (next_req != ack_sync);
  end

  // Register system-side state
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      snap_sys <= '0;
      req <= 1'b0;
      capture_busy <= 1'b0;
    end
    else
    begin
      snap_sys <= next_snap_sys;
      req <= next_req;
      capture_busy <= next_busy;
    end
  end

  // ==========================================================
  // Crossings: request toward link, acknowledge back
  logic req_sync; // Request seen on link_clk
  logic ack; // Link acknowledge toggle

  bit_sync2 u_req_sync
  (
    .clk (link_clk),
    .nrst (nrst),
    .din (req),
    .dout (req_sync)
  );

  bit_sync2 u_ack_sync
  (
    .clk (clk_sys),
    .nrst (nrst),
    .din (ack),
    .dout (ack_sync)
  );

  // ==========================================================
  // Link side: snapshot copy and byte server
  fault_log_pkg::link_state_t state;
  fault_log_pkg::link_state_t next_state;
  logic [SNAP_W-1:0] snap_link; // Link-domain copy of the preamble
  logic [SNAP_W-1:0] next_snap_link;
  logic next_ack;
  logic next_log_ready;
  logic [6:0] idx; // Preamble byte index
  logic [6:0] next_idx;
  logic [7:0] next_rd_byte;
  logic next_rd_valid;
  logic next_cyc_mode;
  logic [5:0] next_cyc_pos;

  // Copy only between frames so a host never sees a mixed log; the
  // multi-bit snapshot has been stable for two link clocks by then
  always_comb
  begin
    next_state = state;
    next_snap_link = snap_link;
    next_ack = ack;
    next_log_ready = log_ready;
    next_idx = idx;
    next_rd_byte = rd_byte;
    next_rd_valid = 1'b0;
    next_cyc_mode = cyc_mode;
    next_cyc_pos = cyc_pos;
    case (state)
      fault_log_pkg::LINK_IDLE:
      begin
        next_cyc_mode = 1'b0;
        if (req_sync != ack)
        begin
          // New snapshot waiting: take it and acknowledge
          next_snap_link = snap_sys;
          next_ack = req_sync;
          next_log_ready = 1'b1;
        end
        else if (frame && log_ready)
        begin
          next_state = fault_log_pkg::LINK_PRE;
          next_idx = '0;
        end
      end
      fault_log_pkg::LINK_PRE:
      begin
        if (!frame)
          next_state = fault_log_pkg::LINK_IDLE;
        else if (rd_strobe)
        begin
          next_rd_byte = snap_link[idx*8 +: 8];
          next_rd_valid = 1'b1;
          next_idx = idx + 7'h01;
          if (idx == 7'(fault_log_pkg::LAST_PRE_BYTE))
          begin
            // Cyclic part starts at the captured pointer
            next_state = fault_log_pkg::LINK_CYC;
            next_cyc_mode = 1'b1;
            next_cyc_pos =
              snap_link[fault_log_pkg::OFS_POS*8 +: 6];
          end
        end
      end
      fault_log_pkg::LINK_CYC:
      begin
        if (!frame)
          next_state = fault_log_pkg::LINK_IDLE;
        else if (rd_strobe)
        begin
          // Byte at cyc_pos is supplied by the cyclic store outside
          next_rd_byte = cyc_byte;
          next_rd_valid = 1'b1;
          if (cyc_pos == 6'h00)
            next_cyc_pos = 6'(fault_log_pkg::LOOP_BYTES - 1);
          else
            next_cyc_pos = cyc_pos - 6'h01;
        end
      end
      default:
      begin
        next_state = fault_log_pkg::LINK_IDLE;
      end
    endcase
  end

  // Register link-side state
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= fault_log_pkg::LINK_IDLE;
      snap_link <= '0;
      ack <= 1'b0;
      log_ready <= 1'b0;
      idx <= 7'h00;
      rd_byte <= 8'h00;
      rd_valid <= 1'b0;
      cyc_mode <= 1'b0;
      cyc_pos <= 6'h00;
    end
    else
    begin
      state <= next_state;
      snap_link <= next_snap_link;
      ack <= next_ack;
      log_ready <= next_log_ready;
      idx <= next_idx;
      rd_byte <= next_rd_byte;
      rd_valid <= next_rd_valid;
      cyc_mode <= next_cyc_mode;
      cyc_pos <= next_cyc_pos;
    end
  end

endmodule // fault_log_preamble_formatter
`default_nettype wire

// ---- tb/fault_log_assertions.sv ----
// Checker for the fault-log formatter, on its top ports.
// Assumes write_pos stays inside the 46-byte loop.
`timescale 1ns/1ns
`default_nettype none
module fault_log_checker
(
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic link_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic capture,
  input wire logic capture_busy,
  input wire logic frame,
  input wire logic rd_strobe,
  input wire logic [7:0] cyc_byte,
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid,
  input wire logic cyc_mode,
  input wire logic [5:0] cyc_pos,
  input wire logic log_ready
);
  // ==========================================================
  // Sequences and helper count
  sequence open_s;
    (frame && log_ready)[*4];
  endsequence
  sequence cyc_read_s;
    cyc_mode && $past(cyc_mode) && rd_valid;
  endsequence
  logic [7:0] n_ans; // Answers since the frame opened
  always_ff @(posedge link_clk or negedge nrst)
    if (!nrst) n_ans <= 8'h00;
    else if (!frame) n_ans <= 8'h00;
    else if (rd_valid) n_ans <= n_ans + 8'h01;
  // ==========================================================
  // Assertions
  take_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      capture && !capture_busy |=> capture_busy) else $error("no take");
  answer_a:
    assert property (@(posedge link_clk) disable iff (!nrst)
      open_s ##0 rd_strobe |=> rd_valid) else $error("no answer");
  cause_a:
    assert property (@(posedge link_clk) disable iff (!nrst)
      rd_valid |-> $past(rd_strobe) && $past(frame)) else $error("cause");
  ready_keep_a:
    assert property (@(posedge link_clk) disable iff (!nrst)
      log_ready |=> log_ready) else $error("ready fell");
  pre_end_a:
    assert property (@(posedge link_clk) disable iff (!nrst) $rose(cyc_mode)
      |-> rd_valid && n_ans == 8'h47 && cyc_pos < 6'h2E) else $error("end");
  cyc_step_a:
    assert property (@(posedge link_clk) disable iff (!nrst) cyc_read_s |->
      cyc_pos == ($past(cyc_pos) == 6'h00 ? 6'h2D : $past(cyc_pos) - 6'h01))
      else $error("cyc step");
  cyc_data_a:
    assert property (@(posedge link_clk) disable iff (!nrst)
      cyc_read_s |-> rd_byte == $past(cyc_byte)) else $error("cyc data");
  cyc_clear_a:
    assert property (@(posedge link_clk) disable iff (!nrst)
      (!frame)[*3] |-> !cyc_mode) else $error("cyc stuck");
endmodule // fault_log_checker
bind fault_log_preamble_formatter fault_log_checker fault_log_checker_inst
  (.*);
`default_nettype wire

// ---- tb/log_host_model.sv ----
// Host reader model for the formatter's link port.
// Assumes link_clk runs free and answers come one edge late.
`timescale 1ns/1ns
`default_nettype none
module log_host_model
(
  // Link clock and answers
  input wire logic link_clk,
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid,
  input wire logic [5:0] cyc_pos,
  // Requests
  output logic frame,
  output logic rd_strobe,
  output logic [7:0] cyc_byte
);
  logic [7:0] got [0:79]; // Bytes received
  int n_got; // Count received
  // Loop byte codes its position; inverted outside frames
  assign cyc_byte = {8{frame}} ~^ ({2'h0, cyc_pos} ^ 8'hA5);
  initial
  begin
    frame = 1'b0;
    rd_strobe = 1'b0;
  end
  // One frame of n reads; slow mode strobes every third edge
  task automatic read_frame(input int n, input bit slow);
    int sent;
    int k;
    sent = 0;
    k = 0;
    n_got = 0;
    @(posedge link_clk) frame <= 1'b1;
    while (n_got < n && k < 1000)
    begin
      @(posedge link_clk);
      k++;
      if (rd_valid === 1'b1)
      begin
        got[n_got] = rd_byte;
        n_got++;
      end
      rd_strobe <= sent < n && (!slow || k % 3 == 0);
      if (sent < n && (!slow || k % 3 == 0))
        sent++;
    end
    frame <= 1'b0;
    rd_strobe <= 1'b0;
    repeat (3) @(posedge link_clk);
  endtask
endmodule // log_host_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the fault-log preamble formatter.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys, link_clk, nrst, capture, capture_busy;
  logic frame, rd_strobe, rd_valid, cyc_mode, log_ready;
  logic [7:0] write_pos, valid_count, rd_byte, cyc_byte;
  logic [5:0] cyc_pos, p;
  logic [40:0] shared_clock_timestamp;
  logic [7:0][15:0] vout_peak, vout_min, status_mfr2;
  logic [15:0] vin_peak, vin_min, temp_peak, temp_min;
  logic [7:0][7:0] status_vout, status_mfr;
  logic [7:0] exp_pre [0:71]; // Preamble expected
  logic [31:0] seed = 32'h00015F28;
  int n_errors = 0;
  int comparisons = 0;
  int k;
  fault_log_preamble_formatter fault_log_preamble_formatter_inst (.*);
  log_host_model log_host_model_inst (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Link clock, 15 ns, offset from clk_sys
  initial
  begin
    link_clk = 1'b0;
    forever
    begin
      #7 link_clk = 1'b1;
      #8 link_clk = 1'b0;
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Fresh snapshot sources; mfr2 upper byte must never show
  task automatic scramble();
    logic [31:0] r;
    for (int c = 0; c < 8; c++)
    begin
      r = rnd();
      {vout_peak[c], vout_min[c]} = {r, rnd()};
      r = rnd();
      {status_vout[c], status_mfr[c], status_mfr2[c]} = r;
    end
    {vin_peak, vin_min, temp_peak, temp_min} = {rnd(), rnd()};
    r = rnd();
    {valid_count, shared_clock_timestamp} = {r[16:0], rnd()};
  endtask
  // Preamble byte i from the current sources
  function automatic logic [7:0] pre_byte(input int i);
    logic [47:0] t;
    logic [15:0] w;
    int s;
    int c;
    t = {7'h00, shared_clock_timestamp};
    s = (i - 8) / 4;
    c = s < 2 ? s : (s < 5 ? s - 1 : s - 2);
    if (i == 0) return write_pos;
    if (i == 1) return valid_count;
    if (i < 8) return t[8 * (i - 2) +: 8];
    if (i >= 48)
    begin
      c = (i - 48) / 3;
      return i % 3 == 0 ? status_vout[c] :
        (i % 3 == 1 ? status_mfr[c] : status_mfr2[c][7:0]);
    end
    w = i % 4 < 2 ? vout_peak[c] : vout_min[c];
    if (s == 2) w = i % 4 < 2 ? vin_peak : vin_min;
    if (s == 5) w = i % 4 < 2 ? temp_peak : temp_min;
    return i % 2 ? w[15:8] : w[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Errors %0d of %0d checks", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Three captures: wrap corners 1 and 0, then random; second slow
  initial
  begin
    nrst = 1'b0;
    capture = 1'b0;
    write_pos = 8'h00;
    scramble();
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) nrst = 1'b1;
    for (int r = 0; r < 3; r++)
    begin
      @(negedge clk_sys);
      scramble();
      write_pos = r == 0 ? 8'h01 : (r == 1 ? 8'h00 : 8'(rnd() % 46));
      for (int i = 0; i < 72; i++) exp_pre[i] = pre_byte(i);
      capture = 1'b1;
      // Held through a busy edge with new data: must be refused
      @(negedge clk_sys) scramble();
      @(negedge clk_sys) capture = 1'b0;
      k = 0;
      while ((capture_busy !== 1'b0 || log_ready !== 1'b1) && k < 300)
      begin
        @(negedge clk_sys);
        k++;
      end
      if (k == 300)
      begin
        // Handshake never settled: count it and go to the report
        n_errors++;
        break;
      end
      // Short frame cut inside the preamble; the next must restart at 0
      log_host_model_inst.read_frame(10, 1'b0);
      for (int i = 0; i < 10; i++)
        check(log_host_model_inst.got[i], exp_pre[i]);
      log_host_model_inst.read_frame(76, r[0]);
      check(8'(log_host_model_inst.n_got), 8'h4C);
      for (int i = 0; i < 72; i++)
        check(log_host_model_inst.got[i], exp_pre[i]);
      p = exp_pre[0][5:0];
      for (int j = 72; j < 76; j++)
      begin
        check(log_host_model_inst.got[j], {2'h0, p} ^ 8'hA5);
        p = p == 6'h00 ? 6'h2D : p - 6'h01;
      end
    end
    close_out();
  end
endmodule // testbench
`default_nettype wire
